// ==== hdl/display_cycle_map.svh ====
// Constants for the display cycle sequencer: zoom limits, field positions, word steps.
// Assumes inclusion by bare name from the design files.
`ifndef DISPLAY_CYCLE_MAP_SVH
`define DISPLAY_CYCLE_MAP_SVH
`define ZOOM_MIN 5'h01
`define ZOOM_MAX 5'h10
`define CLOCKS_PER_ZOOM 6'h02
`define WIDE_BIT_POS 7
`define WIDE_BYTE_GFX_A 4'h3
`define WIDE_BYTE_GFX_B 4'h7
`define WIDE_BYTE_CHR_A 4'hb
`define WIDE_BYTE_CHR_B 4'hf
`define WORD_STEP_NARROW 18'h00001
`define WORD_STEP_WIDE 18'h00002
`define ADDR_RESET 18'h00000
`define LINE_RESET 12'h000
`endif

// ==== hdl/display_cycle_pkg.sv ====
// Types shared by the display cycle sequencer and its testbench.
// Assumes the map header sits beside it.
package display_cycle_pkg;
  typedef enum logic [1:0] {GraphicsMode, CharacterMode, MixedMode} dispMode_t;
  typedef enum logic [1:0] {Idle, FirstClk, SecondClk, ZoomPad} cycState_t;
endpackage

// ==== hdl/strobe_if.sv ====
// Carrier between the sequencer and the strobe shaper.
// Assumes one device clock domain.
interface strobe_if;
  logic firstClk;
  logic secondClk;
  logic padClk;
  modport seq (output firstClk, output secondClk, output padClk);
  modport shape (input firstClk, input secondClk, input padClk);
endinterface

// ==== hdl/strobe_shaper.sv ====
// Shapes the address latch strobe and bus enable from cycle phase flags.
// Assumes strobe_if driven by the sequencer in the core_clk domain.
module strobe_shaper
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Phase flags
  strobe_if.shape ph,
  // Pin controls
  output logic latchStrobe,
  output logic addrOe
);
  logic strobeLowFall_q;
  logic strobeLowFall_d;

  // First clock flag sampled at mid clock; clear again by mid second clock
  always_comb
  begin
    strobeLowFall_d = ph.firstClk;
  end

  always_ff @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
      strobeLowFall_q <= 1'b0;
    else
      strobeLowFall_q <= strobeLowFall_d;
  end

  // Strobe high in first half of first clock and in pad clocks
  // Back to back cycles still see a high first half: flag sampled low mid second
  assign latchStrobe = ~((strobeLowFall_q & ph.firstClk) | ph.secondClk);
  // Address driven only during first clock
  assign addrOe = ph.firstClk;

  pad_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ph.padClk |-> ##0 latchStrobe)
    else $error("strobe low in zoom pad");
  oe_second_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ph.secondClk |-> !addrOe)
    else $error("address driven in second clock");
endmodule

// ==== hdl/display_cycle_seq.sv ====
// Display cycle sequencer: zoom-stretched cycles, strobe, address, line repeat.
// Assumes synchronous inputs on core_clk; external video logic times its own loads.
// Contract
// - Two device clocks per zoom step
// - Zoom one through sixteen, both axes
// - Zoom only in bit-mapped graphics mode
// - Strobe low mid first through second clock
// - Address driven first clock, floated second
// - First two clocks same for any zoom
// - Strobe high during third and later clocks
// - Blank video in non-display cycles
// - Repeat lines per zoom for vertical scaling
// - Wide bit advances address by two
// - Read-modify-write handles single word
// - Character mode wide access is 26 bits
`include "display_cycle_map.svh"
module display_cycle_seq
#(
  parameter int ADDR_W = 18,
  parameter int LINE_W = 12
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Display setup
  input wire display_cycle_pkg::dispMode_t dispMode,
  input wire logic [4:0] zoomFactor,
  input wire logic [7:0] areaParamByte,
  input wire logic [3:0] areaParamIndex,
  input wire logic [ADDR_W-1:0] areaStartAddr,
  input wire logic [ADDR_W-1:0] lineWords,
  // Scan timing
  input wire logic activeReq,
  input wire logic lineStart,
  input wire logic frameStart,
  input wire logic rmwCycle,
  input wire logic refreshCycle,
  // Memory pins
  output logic latchStrobe,
  output logic [15:0] muxAddrOut,
  output logic muxAddrOe,
  output logic blankVideo,
  output logic wideWordOut,
  output logic [4:0] dataWidthOut
);
  import display_cycle_pkg::*;

  cycState_t state_q, state_d;
  logic [5:0] clkCnt_q, clkCnt_d;
  logic [4:0] zoom_q, zoom_d;
  logic [4:0] lineRep_q, lineRep_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_W-1:0] lineBase_q, lineBase_d;
  logic [ADDR_W-1:0] wordCnt_q, wordCnt_d;
  logic wide_q, wide_d;
  logic blank_q, blank_d;
  logic [15:0] addrOut_q, addrOut_d;
  logic [5:0] cycLen;
  logic [4:0] zoomEff;

  strobe_if ph();

  // Effective zoom: clamp to legal range, forced to one outside graphics
  always_comb
  begin
    if (dispMode != GraphicsMode)
      zoomEff = `ZOOM_MIN;
    else if (zoomFactor < `ZOOM_MIN)
      zoomEff = `ZOOM_MIN;
    else if (zoomFactor > `ZOOM_MAX)
      zoomEff = `ZOOM_MAX;
    else
      zoomEff = zoomFactor;
  end

  // Cycle length two clocks per zoom step
  assign cycLen = 6'(zoom_q) * `CLOCKS_PER_ZOOM;

  // Phase flags to shaper; same first two clocks at any zoom
  assign ph.firstClk = (state_q == FirstClk);
  assign ph.secondClk = (state_q == SecondClk);
  assign ph.padClk = (state_q == ZoomPad);

  // Cycle sequencer, address counter, line repeat
  always_comb
  begin
    state_d = state_q;
    clkCnt_d = clkCnt_q;
    zoom_d = zoom_q;
    lineRep_d = lineRep_q;
    addr_d = addr_q;
    lineBase_d = lineBase_q;
    wordCnt_d = wordCnt_q;
    wide_d = wide_q;
    blank_d = blank_q;
    addrOut_d = addrOut_q;
    // Wide bit latched from the area parameter byte
    if ((dispMode == CharacterMode &&
         (areaParamIndex == `WIDE_BYTE_CHR_A || areaParamIndex == `WIDE_BYTE_CHR_B)) ||
        (dispMode != CharacterMode &&
         (areaParamIndex == `WIDE_BYTE_GFX_A || areaParamIndex == `WIDE_BYTE_GFX_B)))
      wide_d = areaParamByte[`WIDE_BIT_POS];
    if (frameStart)
    begin
      addr_d = areaStartAddr;
      lineBase_d = areaStartAddr;
      lineRep_d = 5'h00;
      wordCnt_d = `ADDR_RESET;
    end
    else if (lineStart)
    begin
      wordCnt_d = `ADDR_RESET;
      // Rescan the same line zoom times before moving on
      if (lineRep_q + 5'h01 >= zoomEff)
      begin
        lineRep_d = 5'h00;
        lineBase_d = addr_q;
      end
      else
      begin
        lineRep_d = lineRep_q + 5'h01;
        addr_d = lineBase_q;
      end
    end
    unique case (state_q)
      Idle:
      begin
        if (activeReq | rmwCycle | refreshCycle)
        begin
          state_d = FirstClk;
          zoom_d = (rmwCycle | refreshCycle) ? `ZOOM_MIN : zoomEff;
          blank_d = rmwCycle | refreshCycle | ~activeReq;
          // Issue the pending word, then point at the next one
          addrOut_d = addr_d[15:0];
          if (!blank_d)
            addr_d = addr_d + (wide_q ? `WORD_STEP_WIDE : `WORD_STEP_NARROW);
        end
      end
      FirstClk:
      begin
        state_d = SecondClk;
        clkCnt_d = 6'h02;
      end
      SecondClk, ZoomPad:
      begin
        if (clkCnt_q >= cycLen)
        begin
          state_d = (activeReq | rmwCycle | refreshCycle) ? FirstClk : Idle;
          clkCnt_d = 6'h00;
          zoom_d = (rmwCycle | refreshCycle) ? `ZOOM_MIN : zoomEff;
          blank_d = rmwCycle | refreshCycle | ~activeReq;
          addrOut_d = addr_d[15:0];
          // Blanked cycles leave the display address where it is
          if (state_d == FirstClk && !blank_d)
            addr_d = addr_d + (wide_q ? `WORD_STEP_WIDE : `WORD_STEP_NARROW);
        end
        else
        begin
          state_d = ZoomPad;
          clkCnt_d = clkCnt_q + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= Idle;
      clkCnt_q <= 6'h00;
      zoom_q <= `ZOOM_MIN;
      lineRep_q <= 5'h00;
      addr_q <= `ADDR_RESET;
      lineBase_q <= `ADDR_RESET;
      wordCnt_q <= `ADDR_RESET;
      wide_q <= 1'b0;
      blank_q <= 1'b1;
      addrOut_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      clkCnt_q <= clkCnt_d;
      zoom_q <= zoom_d;
      lineRep_q <= lineRep_d;
      addr_q <= addr_d;
      lineBase_q <= lineBase_d;
      wordCnt_q <= wordCnt_d;
      wide_q <= wide_d;
      blank_q <= blank_d;
      addrOut_q <= addrOut_d;
    end
  end

  strobe_shaper shaper
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .ph(ph),
    .latchStrobe(latchStrobe),
    .addrOe(muxAddrOe)
  );

  // Pin outputs
  assign muxAddrOut = addrOut_q;
  assign blankVideo = blank_q;
  // Wide only in display cycles; read-modify-write stays one word
  assign wideWordOut = wide_q & ~blank_q;
  // Access width: 13 or 16 bits; character 13 doubled to 26 in wide display cycles, graphics stays 16
  assign dataWidthOut = (dispMode == CharacterMode) ?
    ((wide_q & ~blank_q) ? 5'h1a : 5'h0d) :
    ((wide_q & ~blank_q) ? 5'h10 : 5'h10);

  // Cycle step sequences
  sequence firstThenSecond;
    ph.firstClk ##1 ph.secondClk;
  endsequence

  first_second_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ph.firstClk |-> firstThenSecond)
    else $error("second clock did not follow first");
  zoom_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ph.secondClk && zoom_q == 5'h01) |=> !ph.padClk)
    else $error("pad clock at zoom one");
  zoom_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ph.secondClk && zoom_q == 5'h02) |=> ph.padClk ##1 ph.padClk ##1 !ph.padClk)
    else $error("zoom two cycle not four clocks");
  zoom_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (dispMode != GraphicsMode) |-> zoomEff == 5'h01)
    else $error("zoom outside graphics mode");
  zoom_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
    zoom_q >= 5'h01 && zoom_q <= 5'h10)
    else $error("zoom out of range");
  wide_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_d == FirstClk && !blank_d && wide_q && !frameStart && !lineStart)
      |=> addr_q == $past(addr_q) + 18'h00002)
    else $error("wide address step not two");
  strobe_pad_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ph.padClk |-> latchStrobe && !muxAddrOe)
    else $error("strobe or bus active in pad");
  blank_rmw_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_d == FirstClk && (rmwCycle || refreshCycle)) |=> blankVideo && !wideWordOut)
    else $error("rmw cycle not blanked");
  char_width_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (dispMode == CharacterMode && wideWordOut) |-> dataWidthOut == 5'h1a)
    else $error("character wide width wrong");
endmodule

// ==== test/video_load_model.sv ====
// Far-side video logic: pixel divider, load detector, memory strobes, zoom pre-scaler.
// Assumes strobe, address and wide flag are driven in the core_clk domain.
module video_load_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pins from the sequencer
  input wire logic latchStrobe,
  input wire logic [15:0] muxAddrOut,
  input wire logic muxAddrOe,
  input wire logic wideWordOut,
  // Host zoom register contents
  input wire logic [4:0] hostZoom,
  // Loads seen
  output logic [15:0] loadCount,
  output logic [31:0] loadWord,
  output logic [7:0] lastRun,
  output logic [15:0] memLate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic qual;
  logic pixClk = 1'b0;
  logic [2:0] pixDiv = 3'h7;
  logic [3:0] preScale;
  logic [3:0] reloadReg;
  logic [2:0] strobeDly;
  logic [31:0] videoShiftReg;
  logic [7:0] runCnt;
  logic [15:0] addrLatch = 16'h0000;
  logic wideLatch = 1'b0;
  logic loadEn;
  logic carry;
  logic rowActive;
  logic colActive;

  // Pixel clock eight times the device clock, phased after each rising edge
  always @(posedge core_clk)
  begin
    #1.25;
    for (int i = 0; i < 16; i++)
    begin
      pixClk = ~pixClk;
      if (i < 15)
        #2.5;
    end
  end

  // Divide by eight; terminal count straddles each rising device clock edge
  always @(posedge pixClk)
    pixDiv <= pixDiv + 3'h1;

  // Host register presents the pre-scaler reload value at all times
  assign reloadReg = 4'(5'h10 - hostZoom);

  // Strobe sampled on every falling edge
  always @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
      qual <= 1'b0;
    else
      qual <= ~latchStrobe;
  end

  // Word address and width captured while the bus carries them
  always @(negedge core_clk)
  begin
    if (muxAddrOe)
    begin
      addrLatch <= muxAddrOut;
      wideLatch <= wideWordOut;
    end
  end

  // Load enable, pre-scaler carry and delayed memory strobes
  assign loadEn = (pixDiv == 3'h7) & qual;
  assign carry = (preScale == 4'hf);
  assign rowActive = strobeDly[0];
  assign colActive = strobeDly[2];

  // Pixel domain: strobe delay line, pre-scaler, shift register
  always @(posedge pixClk or negedge rstn)
  begin
    if (!rstn)
    begin
      strobeDly <= 3'h0;
      preScale <= 4'hf;
      videoShiftReg <= 32'h00000000;
      loadWord <= 32'h00000000;
      lastRun <= 8'h00;
      runCnt <= 8'h00;
      memLate <= 16'h0000;
    end
    else
    begin
      strobeDly <= {strobeDly[1:0], ~latchStrobe};
      if (carry | loadEn)
        preScale <= reloadReg;
      else
        preScale <= preScale + 4'h1;
      if (loadEn)
      begin
        // Even and odd words side by side in wide cycles
        videoShiftReg <= wideLatch ? {addrLatch | 16'h0001, addrLatch & 16'hfffe} :
          {16'h0000, addrLatch};
        loadWord <= wideLatch ? {addrLatch | 16'h0001, addrLatch & 16'hfffe} :
          {16'h0000, addrLatch};
        lastRun <= runCnt;
        runCnt <= 8'h00;
        if (!(rowActive & colActive))
          memLate <= memLate + 16'h0001;
      end
      else if (carry)
      begin
        videoShiftReg <= {videoShiftReg[30:0], 1'b0};
        runCnt <= runCnt + 8'h01;
      end
    end
  end

  // Load at the rising edge closing a qualified clock
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      loadCount <= 16'h0000;
    else if (qual)
      loadCount <= loadCount + 16'h0001;
  end
endmodule

// ==== test/display_cycle_zoom_video_load_test.sv ====
// Bench for the display cycle sequencer with a far-side load model.
// Assumes the design files and the load model are compiled first.
module display_cycle_zoom_video_load_test;
  timeunit 1ns;
  timeprecision 1ps;
  import display_cycle_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  dispMode_t dispMode = GraphicsMode;
  logic [4:0] zoomFactor = 5'h01;
  logic [7:0] areaParamByte = 8'h00;
  logic [3:0] areaParamIndex = 4'h0;
  logic [17:0] areaStartAddr = 18'h00100;
  logic activeReq = 1'b0;
  logic lineStart = 1'b0;
  logic frameStart = 1'b0;
  logic rmwCycle = 1'b0;
  logic refreshCycle = 1'b0;
  logic [4:0] hostZoom = 5'h01;
  logic [31:0] loadWord;
  logic [7:0] lastRun;
  logic [15:0] memLate;
  logic latchStrobe, muxAddrOe, blankVideo, wideWordOut;
  logic [15:0] muxAddrOut, loads;
  logic [4:0] dataWidthOut;
  int error_cnt = 0;
  int check_count = 0;

  // Device clock, 40 ns period
  always #20 core_clk = ~core_clk;

  display_cycle_seq uut (.core_clk(core_clk), .rstn(rstn), .dispMode(dispMode),
    .zoomFactor(zoomFactor), .areaParamByte(areaParamByte), .areaParamIndex(areaParamIndex),
    .areaStartAddr(areaStartAddr), .lineWords(18'h00000), .activeReq(activeReq),
    .lineStart(lineStart), .frameStart(frameStart), .rmwCycle(rmwCycle),
    .refreshCycle(refreshCycle), .latchStrobe(latchStrobe), .muxAddrOut(muxAddrOut),
    .muxAddrOe(muxAddrOe), .blankVideo(blankVideo), .wideWordOut(wideWordOut),
    .dataWidthOut(dataWidthOut));

  video_load_model partner (.core_clk(core_clk), .rstn(rstn), .latchStrobe(latchStrobe),
    .muxAddrOut(muxAddrOut), .muxAddrOe(muxAddrOe), .wideWordOut(wideWordOut),
    .hostZoom(hostZoom), .loadCount(loads), .loadWord(loadWord), .lastRun(lastRun),
    .memLate(memLate));

  // Counts a compare and reports a mismatch
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Prints counts and verdict, ends the run
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bounded wait for the first clock of a cycle
  task automatic waitStart();
    for (int i = 0; i < 100; i++)
    begin
      @(posedge core_clk);
      #5;
      if (muxAddrOe === 1'b1)
        return;
    end
    chk(1'b0, "no cycle start");
    results();
  endtask

  // Applies setup inputs at the falling edge
  task automatic setup(input dispMode_t m, input logic [4:0] z, input logic [3:0] idx,
    input logic [7:0] b, input logic act, input logic rmw);
    @(negedge core_clk);
    dispMode = m;
    zoomFactor = z;
    areaParamIndex = idx;
    areaParamByte = b;
    activeReq = act;
    rmwCycle = rmw;
    // Host programs the pre-scaler for the zoom the device uses in display cycles
    hostZoom = (m == GraphicsMode) ? z : 5'h01;
  endtask

  // Walks one whole cycle after a settling cycle and judges its shape
  task automatic measure(input logic [4:0] z, input logic [15:0] step, input logic blank,
    input logic [4:0] width);
    logic [15:0] a, l;
    waitStart();
    waitStart();
    a = muxAddrOut;
    l = loads;
    chk(latchStrobe === 1'b1, "strobe low in first half");
    chk(dataWidthOut === width, "data width");
    if (step != 16'h0000)
      chk(wideWordOut === (step == 16'h0002), "wide flag");
    else
      chk(wideWordOut === 1'b0, "single word in blanked cycle");
    @(negedge core_clk);
    #5;
    chk(latchStrobe === 1'b0 && muxAddrOe === 1'b1, "first clock shape");
    @(posedge core_clk);
    #5;
    chk(latchStrobe === 1'b0 && muxAddrOe === 1'b0, "second clock shape");
    chk(blankVideo === blank, "blanking");
    for (int n = 1; n < 2 * z - 1; n++)
    begin
      @(posedge core_clk);
      #5;
      chk(latchStrobe === 1'b1 && muxAddrOe === 1'b0, "pad clock shape");
    end
    @(posedge core_clk);
    #5;
    chk(muxAddrOe === 1'b1, "cycle length");
    chk(loads === l + 16'h0001, "one load per cycle");
    if (step != 16'h0000)
      chk(muxAddrOut === a + step, "address step");
    chk(memLate === 16'h0000, "memory data late at load");
    // Sixteen pixels a word: fifteen shifts between loads at any zoom
    if (!blank)
      chk(lastRun === 8'h0f, "pixels per word");
    if (step == 16'h0002)
      chk(loadWord === {a | 16'h0001, a & 16'hfffe}, "wide loaded word");
    else if (step == 16'h0001)
      chk(loadWord === {16'h0000, a}, "loaded word");
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    #5;
    chk(latchStrobe === 1'b1 && muxAddrOe === 1'b0 && blankVideo === 1'b1, "reset");
    @(negedge core_clk);
    rstn = 1'b1;
    frameStart = 1'b1;
    @(negedge core_clk);
    frameStart = 1'b0;
    setup(GraphicsMode, 5'h01, 4'h0, 8'h00, 1'b1, 1'b0);
    measure(5'h01, 16'h0001, 1'b0, 5'h10);
    setup(GraphicsMode, 5'h03, 4'h0, 8'h00, 1'b1, 1'b0);
    measure(5'h03, 16'h0001, 1'b0, 5'h10);
    setup(GraphicsMode, 5'h10, 4'h0, 8'h00, 1'b1, 1'b0);
    measure(5'h10, 16'h0001, 1'b0, 5'h10);
    setup(CharacterMode, 5'h04, 4'h0, 8'h00, 1'b1, 1'b0);
    measure(5'h01, 16'h0001, 1'b0, 5'h0d);
    setup(GraphicsMode, 5'h01, 4'h3, 8'h80, 1'b1, 1'b0);
    measure(5'h01, 16'h0002, 1'b0, 5'h10);
    setup(GraphicsMode, 5'h01, 4'h7, 8'h80, 1'b1, 1'b0);
    measure(5'h01, 16'h0002, 1'b0, 5'h10);
    setup(CharacterMode, 5'h01, 4'hb, 8'h80, 1'b1, 1'b0);
    measure(5'h01, 16'h0002, 1'b0, 5'h1a);
    setup(GraphicsMode, 5'h02, 4'h3, 8'h80, 1'b0, 1'b1);
    measure(5'h01, 16'h0000, 1'b1, 5'h10);
    @(negedge core_clk);
    rmwCycle = 1'b0;
    refreshCycle = 1'b1;
    measure(5'h01, 16'h0000, 1'b1, 5'h10);
    @(negedge core_clk);
    refreshCycle = 1'b0;
    setup(GraphicsMode, 5'h02, 4'h3, 8'h00, 1'b1, 1'b0);
    measure(5'h02, 16'h0001, 1'b0, 5'h10);
    // Line start in a first clock: next cycle rescans from the line base
    @(negedge core_clk);
    lineStart = 1'b1;
    @(negedge core_clk);
    lineStart = 1'b0;
    waitStart();
    chk(muxAddrOut === areaStartAddr[15:0], "line rescan address");
    measure(5'h02, 16'h0001, 1'b0, 5'h10);
    results();
  end
endmodule
